// File: verilog/rfc_pkg.sv
// package: register map, field layout, timing counts and carriers of the receive framer control bank
package rfc_pkg;

  localparam int          ADDR_W         = 16;
  // register word indices of one port; the byte address is four times the index
  localparam logic [13:0] HDLC_CTRL_IDX  = 14'h0010;
  localparam logic [13:0] HDLC_SUPP_IDX  = 14'h0011;
  localparam logic [13:0] MON_SEL_IDX    = 14'h0012;
  localparam logic [13:0] SIG_CTRL_IDX   = 14'h0013;
  localparam logic [13:0] MON_VAL_IDX    = 14'h001f;
  localparam logic [13:0] ONES_MASK_IDX  = 14'h0038;
  localparam int          ONES_MASK_REGS = 3;
  localparam logic [13:0] PORT_STRIDE    = 14'h0200;
  localparam logic [13:0] BANK_STRIDE    = 14'h2000;
  localparam int          PORTS_PER_BANK = 8;

  // rx_hdlc_control fields
  localparam int          CRC_DISP_BIT   = 7;
  localparam int          HDLC_RST_BIT   = 6;
  localparam int          MAP_SEL_BIT    = 5;
  localparam int          CHAN_SEL_LSB   = 0;
  localparam int          CHAN_W         = 5;
  // rx_signalling_control fields; bit 4 is force_sig_ones in T1, cas_resync_mode in E1
  localparam int          SIG_ONES_BIT   = 4;
  localparam int          FORCE_FRZ_BIT  = 2;
  localparam int          FRZ_ALLOW_BIT  = 1;
  localparam int          INTEG_BIT      = 0;
  // reset values and writable masks
  localparam logic [7:0]  REG_RESET      = 8'h00;
  localparam logic [7:0]  MON_SEL_MASK   = 8'h1f;
  localparam logic [7:0]  SIG_CTRL_MASK  = 8'h17;

  // timing counts
  localparam int          HDLC_RST_FRAMES = 2;
  localparam int          INTEG_MFRAMES   = 3;
  localparam int          MFAS_ERR_LIMIT  = 2;
  localparam int          FRAMES_PER_MF   = 16;
  localparam int          SIG_TS          = 16;
  localparam int          T1_CHANNELS     = 24;
  localparam int          NUM_CHANNELS    = 32;

  // one received timeslot from the framer
  typedef struct packed {
    logic       valid;
    logic [4:0] num;
    logic [7:0] data;
    logic [3:0] sig;
    logic       sig_upd;
    logic       sig_frame;
    logic [1:0] sig_sel;
  } rfc_ts_type;

  // one unit handed to the receive HDLC controller
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic [7:0] bit_en;
  } rfc_hdlc_type;

  // per-channel signalling history
  typedef struct packed {
    logic [1:0] cnt;
    logic [3:0] cand;
    logic [3:0] held;
  } rfc_sig_entry_type;

  typedef enum logic {CAS_HUNT, CAS_SYNC} rfc_cas_state_type;

endpackage : rfc_pkg

// File: verilog/rfc_sig_mem.sv
// per-channel signalling store with a registered read port
`timescale 1ns/1ps
module rfc_sig_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  // clock
  input  wire logic             clk,
  // write side
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read side
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  // no reset on the array; the owner tracks which entries hold data
  always_ff @(posedge clk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end

  // read before write when addresses meet in one cycle
  always_ff @(posedge clk)
  begin
    rdata_q <= mem[raddr];
  end

endmodule : rfc_sig_mem

// File: verilog/rfc_regs.sv
// receive framer control registers of one port with hdlc routing, monitor, cas alignment and signalling
//
// Contract
// - crc display bit set: crc-16 goes to the hdlc fifo after the last octet.
// - hdlc reset bit resets the hdlc receiver and fifo, then clears itself.
// - a requested hdlc reset completes within two frame periods.
// - map select 0 feeds hdlc from a channel, 1 from fdl or sa bits.
// - five-bit channel select picks the hdlc channel; zero means channel 1.
// - a new hdlc channel select takes effect only when an hdlc reset completes.
// - five-bit monitor select picks which channel shows in the monitor readback.
// - t1 force-ones replaces robbed-bit signalling with ones on masked channels.
// - e1: two consecutive errored multiframe alignment signals start a resync.
// - cas mode 1 also resyncs on a multiframe whose timeslot 16 is all zero.
// - cas mode 1 aligns only if the preceding timeslot 16 holds a one.
// - force-freeze freezes signalling outputs and overrides the receive freeze enable.
// - freeze-allow 0 never freezes signalling; 1 permits freezing.
// - integration on: signalling must be stable three multiframes before reporting.
// - ones insertion affects the serial output only; signalling output stays actual.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module rfc_regs
  import rfc_pkg::*;
#(
  parameter int PORT_N = 1
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // framer side
  input  wire logic              e1_mode,
  input  wire logic              frame_tick,
  input  wire rfc_ts_type        rx_ts,
  input  wire logic              fdl_valid,
  input  wire logic              fdl_bit,
  input  wire logic              sa_valid,
  input  wire logic              sa_bit,
  input  wire logic              rx_freeze_en,
  input  wire logic              freeze_req,
  input  wire logic              sig_reinsert_en,
  // hdlc receiver
  output rfc_hdlc_type           hdlc_q,
  output logic                   hdlc_reset_q,
  output logic                   crc_to_fifo_en_q,
  // signalling outputs
  output logic                   rx_sig_valid_q,
  output logic      [3:0]        rx_sig_out_q,
  output logic      [7:0]        rx_serial_out_q,
  output logic                   sig_change_q,
  output logic      [4:0]        sig_change_chan_q,
  // e1 cas alignment
  output logic                   cas_mf_locked_q,
  output logic                   cas_resync_q
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  localparam logic [13:0] PORT_BASE = 14'(PORT_STRIDE * (PORT_N - 1) + BANK_STRIDE * ((PORT_N - 1) / PORTS_PER_BANK));
  localparam logic [1:0]  RST_LAST  = 2'(HDLC_RST_FRAMES - 1);
  localparam logic [1:0]  INTEG_CNT = 2'(INTEG_MFRAMES);
  localparam logic [1:0]  ERR_LAST  = 2'(MFAS_ERR_LIMIT - 1);
  localparam logic [3:0]  MF_LAST   = 4'(FRAMES_PER_MF - 1);

  logic [7:0]  ctrl_q;
  logic [7:0]  supp_q;
  logic [7:0]  mon_sel_q;
  logic [7:0]  sig_ctrl_q;
  logic [7:0]  mon_val_q;
  logic [7:0]  ones_q [ONES_MASK_REGS];
  logic [23:0] ones_flat;
  logic [13:0] widx;
  logic        map_hit;
  logic [7:0]  rd_d;
  logic        acc_first;
  logic        wr_en;
  logic        ctrl_wr;
  logic [1:0]  rst_ticks_q;
  logic        rst_done;
  logic [4:0]  active_chan_q;

  assign widx      = paddr[ADDR_W-1:2];
  assign acc_first = psel && penable && !pready;
  assign wr_en     = psel && penable && pready && pwrite && map_hit;
  assign ctrl_wr   = wr_en && (widx == PORT_BASE + HDLC_CTRL_IDX);
  assign ones_flat = {ones_q[2], ones_q[1], ones_q[0]};

  // word decode of this port's copy; misaligned bytes are unmapped
  always_comb
  begin
    map_hit = (paddr[1:0] == 2'h0);
    rd_d    = 8'h00;
    case (widx - PORT_BASE)
      HDLC_CTRL_IDX: rd_d = ctrl_q;
      HDLC_SUPP_IDX: rd_d = supp_q;
      MON_SEL_IDX:   rd_d = mon_sel_q;
      SIG_CTRL_IDX:  rd_d = sig_ctrl_q;
      MON_VAL_IDX:   rd_d = mon_val_q;
      ONES_MASK_IDX: rd_d = ones_q[0];
      ONES_MASK_IDX + 14'h0001: rd_d = ones_q[1];
      ONES_MASK_IDX + 14'h0002: rd_d = ones_q[2];
      default:       map_hit = 1'b0;
    endcase
  end

  // one wait state: answer comes the cycle after the first access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= acc_first;
      pslverr <= acc_first && !map_hit;
      if (acc_first && !pwrite)
        prdata <= {24'h00_0000, map_hit ? rd_d : 8'h00}; // refused reads return zero, not a neighbour
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers

  // reset bit: a host write of one wins over the completion clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_q <= REG_RESET;
    else if (ctrl_wr)
    begin
      ctrl_q               <= pwdata[7:0];
      ctrl_q[HDLC_RST_BIT] <= pwdata[HDLC_RST_BIT] || (ctrl_q[HDLC_RST_BIT] && !rst_done);
    end
    else if (rst_done)
      ctrl_q[HDLC_RST_BIT] <= 1'b0;
  end

  // plain read/write registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      supp_q     <= REG_RESET;
      mon_sel_q  <= REG_RESET;
      sig_ctrl_q <= REG_RESET;
      for (int i = 0; i < ONES_MASK_REGS; i++)
        ones_q[i] <= REG_RESET;
    end
    else if (wr_en)
    begin
      if (widx == PORT_BASE + HDLC_SUPP_IDX)
        supp_q <= pwdata[7:0];
      if (widx == PORT_BASE + MON_SEL_IDX)
        mon_sel_q <= pwdata[7:0] & MON_SEL_MASK;
      if (widx == PORT_BASE + SIG_CTRL_IDX)
        sig_ctrl_q <= pwdata[7:0] & SIG_CTRL_MASK;
      for (int i = 0; i < ONES_MASK_REGS; i++)
        if (widx == PORT_BASE + ONES_MASK_IDX + 14'(i))
          ones_q[i] <= pwdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // hdlc reset sequencing

  // counting two frame ticks guarantees at least one whole frame of flush
  assign rst_done = ctrl_q[HDLC_RST_BIT] && frame_tick && (rst_ticks_q == RST_LAST);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rst_ticks_q <= 2'h0;
    else if (!ctrl_q[HDLC_RST_BIT] || rst_done)
      rst_ticks_q <= 2'h0;
    else if (frame_tick)
      rst_ticks_q <= rst_ticks_q + 2'h1;
  end

  // the channel select is latched only when a reset finishes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      active_chan_q <= 5'h00;
    else if (rst_done)
      active_chan_q <= ctrl_q[CHAN_SEL_LSB +: CHAN_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // hdlc feed and monitor

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hdlc_q           <= '0;
      hdlc_reset_q     <= 1'b0;
      crc_to_fifo_en_q <= 1'b0;
    end
    else
    begin
      hdlc_reset_q     <= ctrl_q[HDLC_RST_BIT];
      crc_to_fifo_en_q <= ctrl_q[CRC_DISP_BIT];
      hdlc_q.valid     <= 1'b0;
      if (ctrl_q[HDLC_RST_BIT])
        hdlc_q.valid <= 1'b0;
      else if (!ctrl_q[MAP_SEL_BIT])
      begin
        if (rx_ts.valid && rx_ts.num == active_chan_q)
        begin
          hdlc_q.valid  <= 1'b1;
          hdlc_q.data   <= rx_ts.data;
          hdlc_q.bit_en <= ~supp_q;
        end
      end
      else if (e1_mode ? sa_valid : fdl_valid)
      begin
        hdlc_q.valid  <= 1'b1;
        hdlc_q.data   <= {7'h00, e1_mode ? sa_bit : fdl_bit};
        hdlc_q.bit_en <= 8'h01;
      end
    end
  end

  // monitor keeps the last byte of the chosen channel
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      mon_val_q <= REG_RESET;
    else if (rx_ts.valid && rx_ts.num == mon_sel_q[4:0])
      mon_val_q <= rx_ts.data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // e1 cas multiframe alignment

  rfc_cas_state_type cas_state_q;
  logic [3:0]        mf_frame_q;
  logic [1:0]        mfas_err_q;
  logic              mf_zero_q;
  logic              prev_one_q;
  logic              ts16;
  logic              mfas_ok;
  logic              cas_mode;

  assign ts16     = e1_mode && rx_ts.valid && (rx_ts.num == 5'(SIG_TS));
  assign mfas_ok  = (rx_ts.data[7:4] == 4'h0);
  assign cas_mode = sig_ctrl_q[SIG_ONES_BIT];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cas_state_q  <= CAS_HUNT;
      mf_frame_q   <= 4'h0;
      mfas_err_q   <= 2'h0;
      mf_zero_q    <= 1'b0;
      prev_one_q   <= 1'b0;
      cas_resync_q <= 1'b0;
    end
    else
    begin
      cas_resync_q <= 1'b0;
      if (!e1_mode)
        cas_state_q <= CAS_HUNT;
      else if (ts16)
      begin
        prev_one_q <= |rx_ts.data;
        mf_frame_q <= mf_frame_q + 4'h1;
        mf_zero_q  <= (mf_frame_q == 4'h0) ? (rx_ts.data == 8'h00) : (mf_zero_q && rx_ts.data == 8'h00);
        case (cas_state_q)
          CAS_HUNT:
            if (mfas_ok && (!cas_mode || prev_one_q))
            begin
              cas_state_q <= CAS_SYNC;
              mf_frame_q  <= 4'h1;
              mfas_err_q  <= 2'h0;
              mf_zero_q   <= (rx_ts.data == 8'h00);
            end
          CAS_SYNC:
            if (mf_frame_q == 4'h0 && !mfas_ok && mfas_err_q == ERR_LAST)
            begin
              cas_state_q  <= CAS_HUNT;
              cas_resync_q <= 1'b1;
            end
            else if (cas_mode && mf_frame_q == MF_LAST && mf_zero_q && rx_ts.data == 8'h00)
            begin
              cas_state_q  <= CAS_HUNT;
              cas_resync_q <= 1'b1;
            end
            else if (mf_frame_q == 4'h0)
              mfas_err_q <= mfas_ok ? 2'h0 : mfas_err_q + 2'h1;
          default:
            cas_state_q <= CAS_HUNT;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cas_mf_locked_q <= 1'b0;
    else
      cas_mf_locked_q <= (cas_state_q == CAS_SYNC);
  end

  ////////////////////////////////////////////////////////////////////////////
  // signalling: integration, freeze and ones insertion

  rfc_ts_type          s1_q;
  rfc_sig_entry_type   ent_q;
  rfc_sig_entry_type   ent_d;
  logic [9:0]          mem_rdata;
  logic [31:0]         seen_q;
  logic                report;
  logic                frozen;
  logic                mem_we;
  logic                ones_hit;
  logic [7:0]          ser_d;

  // freezing needs the allow bit; force then wins over the freeze enable
  assign frozen   = sig_ctrl_q[FRZ_ALLOW_BIT] && (sig_ctrl_q[FORCE_FRZ_BIT] || (rx_freeze_en && freeze_req));
  assign mem_we   = s1_q.valid && s1_q.sig_upd && !frozen;
  assign ones_hit = !e1_mode && sig_ctrl_q[SIG_ONES_BIT] && s1_q.num < 5'(T1_CHANNELS) && ones_flat[s1_q.num];
  // an entry never written reads as settled on the live value
  assign ent_q    = seen_q[s1_q.num] ? rfc_sig_entry_type'(mem_rdata) : {2'h0, s1_q.sig, s1_q.sig};

  rfc_sig_mem #(
    .WIDTH ($bits(rfc_sig_entry_type)),
    .DEPTH (NUM_CHANNELS),
    .AW    (5)
  ) u_sig_mem (
    .clk     (pclk),
    .we      (mem_we),
    .waddr   (s1_q.num),
    .wdata   (ent_d),
    .raddr   (rx_ts.num),
    .rdata_q (mem_rdata)
  );

  // one stage so the stored entry lines up with its timeslot
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q   <= '0;
      seen_q <= 32'h0000_0000;
    end
    else
    begin
      s1_q <= rx_ts;
      if (mem_we)
        seen_q[s1_q.num] <= 1'b1;
    end
  end

  always_comb
  begin
    ent_d  = ent_q;
    report = 1'b0;
    if (!sig_ctrl_q[INTEG_BIT])
    begin
      report     = (s1_q.sig != ent_q.held);
      ent_d.held = s1_q.sig;
      ent_d.cand = s1_q.sig;
      ent_d.cnt  = 2'h0;
    end
    else
    begin
      if (s1_q.sig == ent_q.cand)
        ent_d.cnt = (ent_q.cnt == INTEG_CNT) ? INTEG_CNT : ent_q.cnt + 2'h1;
      else
      begin
        ent_d.cand = s1_q.sig;
        ent_d.cnt  = 2'h1;
      end
      if (ent_d.cnt == INTEG_CNT && ent_d.cand != ent_q.held)
      begin
        report     = 1'b1;
        ent_d.held = ent_d.cand;
      end
    end
  end

  // serial byte: frozen reinsertion first, then ones insertion on top
  always_comb
  begin
    ser_d = s1_q.data;
    if (s1_q.sig_frame && frozen && sig_reinsert_en)
      ser_d[0] = ent_q.held[s1_q.sig_sel];
    if (s1_q.sig_frame && ones_hit)
      ser_d[0] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_sig_valid_q    <= 1'b0;
      rx_sig_out_q      <= 4'h0;
      rx_serial_out_q   <= 8'h00;
      sig_change_q      <= 1'b0;
      sig_change_chan_q <= 5'h00;
    end
    else
    begin
      rx_sig_valid_q    <= s1_q.valid;
      rx_sig_out_q      <= frozen ? ent_q.held : s1_q.sig;
      rx_serial_out_q   <= ser_d;
      sig_change_q      <= mem_we && report;
      sig_change_chan_q <= s1_q.num;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_crc_display: assert property ($rose(ctrl_q[CRC_DISP_BIT]) |=> crc_to_fifo_en_q)
    else $error("crc display enable not passed on");
  a_reset_drive: assert property (ctrl_q[HDLC_RST_BIT] |=> hdlc_reset_q && !hdlc_q.valid)
    else $error("hdlc reset not driven");
  a_reset_bound: assert property (ctrl_q[HDLC_RST_BIT] && frame_tick && rst_ticks_q == 2'h1 && !ctrl_wr
    |=> !ctrl_q[HDLC_RST_BIT])
    else $error("hdlc reset not finished in two frames");
  a_chan_apply: assert property (!$stable(active_chan_q) |-> $past(rst_done))
    else $error("channel select applied outside reset completion");
  a_chan_route: assert property (rx_ts.valid && rx_ts.num == active_chan_q && ctrl_q[6:5] == 2'h0
    |=> hdlc_q.valid && hdlc_q.data == $past(rx_ts.data))
    else $error("selected channel not routed to hdlc");
  a_bit_suppress: assert property (rx_ts.valid && rx_ts.num == active_chan_q && ctrl_q[6:5] == 2'h0
    |=> hdlc_q.bit_en == ~$past(supp_q))
    else $error("suppress mask not applied");
  a_ovh_route: assert property (ctrl_q[MAP_SEL_BIT] |=> !hdlc_q.valid || hdlc_q.bit_en == 8'h01)
    else $error("overhead mapping carried a channel byte");
  a_monitor_pick: assert property (rx_ts.valid && rx_ts.num == mon_sel_q[4:0]
    |=> mon_val_q == $past(rx_ts.data))
    else $error("monitor value not captured");
  a_ones_insert: assert property (s1_q.sig_frame && ones_hit && !frozen
    |=> rx_serial_out_q[0] && rx_sig_out_q == $past(s1_q.sig))
    else $error("ones insertion wrong");
  a_freeze_allow: assert property (!sig_ctrl_q[FRZ_ALLOW_BIT] |=> rx_sig_out_q == $past(s1_q.sig))
    else $error("signalling frozen without allow");
  a_mfas_resync: assert property (cas_state_q == CAS_SYNC && ts16 && mf_frame_q == 4'h0 && !mfas_ok
    && mfas_err_q == 2'h1 |=> cas_resync_q && cas_state_q == CAS_HUNT)
    else $error("no resync after two errored alignment signals");

endmodule : rfc_regs

// File: tb/rfc_host_model.sv
// apb host model that configures the register bank of one framer port
`timescale 1ns/1ps
module rfc_host_model
  import rfc_pkg::*;
(
  // clock
  input  wire logic              pclk,
  // apb master side
  output logic                   psel,
  output logic                   penable,
  output logic                   pwrite,
  output logic      [ADDR_W-1:0] paddr,
  output logic      [31:0]       pwdata,
  input  wire logic [31:0]       prdata,
  input  wire logic              pready,
  input  wire logic              pslverr
);
  // idle bus from time zero so the slave never sees an unknown select
  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = '0;
    pwdata  = '0;
  end

  // one transfer; the request stands until pready is sampled high or 16 cycles pass, after which the slave is flagged as hung
  task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err, output logic hung);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    hung = (pready !== 1'b1);
    rd   = prdata[7:0];
    err  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : rfc_host_model

// File: tb/rfc_regs_bench.sv
// self-checking bench of the receive framer control registers of one port
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); end end
module rfc_regs_bench;
  import rfc_pkg::*;
  localparam int     PORT  = 10;
  localparam int     FRAME = 64;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata;
  logic              e1_mode, frame_tick, fdl_valid, fdl_bit, sa_valid, sa_bit;
  logic              rx_freeze_en, freeze_req, sig_reinsert_en;
  rfc_ts_type        rx_ts;
  rfc_hdlc_type      hdlc_q;
  logic              hdlc_reset_q, crc_q, sig_valid;
  logic [3:0]        sig_out;
  logic [7:0]        ser_out, rd, v, d, supp;
  logic              err, hung, sig_change, locked, resync;
  int                mismatches, comparisons, fcnt;
  logic [13:0]       idx_tab [4] = '{HDLC_CTRL_IDX, HDLC_SUPP_IDX, MON_SEL_IDX, SIG_CTRL_IDX};
  logic [7:0]        msk_tab [4] = '{8'hbf, 8'hff, MON_SEL_MASK, SIG_CTRL_MASK};

  rfc_regs #(.PORT_N(PORT)) u_rfc_regs (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .e1_mode(e1_mode),
    .frame_tick(frame_tick), .rx_ts(rx_ts), .fdl_valid(fdl_valid), .fdl_bit(fdl_bit),
    .sa_valid(sa_valid), .sa_bit(sa_bit), .rx_freeze_en(rx_freeze_en), .freeze_req(freeze_req),
    .sig_reinsert_en(sig_reinsert_en), .hdlc_q(hdlc_q), .hdlc_reset_q(hdlc_reset_q),
    .crc_to_fifo_en_q(crc_q), .rx_sig_valid_q(sig_valid), .rx_sig_out_q(sig_out),
    .rx_serial_out_q(ser_out), .sig_change_q(sig_change), .sig_change_chan_q(), .cas_mf_locked_q(locked),
    .cas_resync_q(resync));

  rfc_host_model u_rfc_host_model (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  ////////////////////////////////////////////////////////////////////////////////
  // 250 MHz clock and a frame strobe every FRAME cycles, short to keep the run brief
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    fcnt       <= (fcnt == FRAME - 1) ? 0 : fcnt + 1;
    frame_tick <= (fcnt == FRAME - 1);
  end

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [ADDR_W-1:0] addr_of(input logic [13:0] idx, input int n);
    return ADDR_W'(4 * (int'(idx) + 'h200 * (n - 1) + 'h2000 * ((n - 1) / 8)));
  endfunction : addr_of

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  // register access of one port, lo picks a byte inside the word; a hung slave ends the run
  task automatic acc(input logic w, input logic [13:0] idx, input logic [7:0] wd, input int n,
                     input logic [1:0] lo = 2'h0);
    u_rfc_host_model.xfer(w, addr_of(idx, n) | {14'h0000, lo}, wd, rd, err, hung);
    if (hung)
    begin
      mismatches++;
      stop_test();
    end
  endtask : acc

  // one received timeslot; high nibble of the byte doubles as its signalling
  task automatic send_ts(input logic [4:0] num, input logic [7:0] dat, input logic sf);
    @(posedge pclk);
    rx_ts <= '{1'b1, num, dat, dat[7:4], 1'b1, sf, 2'd0};
    @(posedge pclk);
    rx_ts.valid <= 1'b0;
    #1;
  endtask : send_ts

  // request an hdlc reset and time how long the busy flag stands
  task automatic hdlc_reset(input logic [7:0] c);
    int n;
    n = 0;
    acc(1'b1, HDLC_CTRL_IDX, c | 8'h40, PORT);
    repeat (2 * FRAME + 4)
    begin
      @(posedge pclk);
      #1;
      if (hdlc_reset_q === 1'b1) n++;
    end
    `CHK(n > 0 && n <= 2 * FRAME + 1, 1'b1)
    acc(1'b0, HDLC_CTRL_IDX, 8'h00, PORT);
    `CHK(rd, c)
  endtask : hdlc_reset

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {presetn, e1_mode, fcnt, frame_tick, fdl_valid, fdl_bit, sa_valid, sa_bit} = '0;
    {rx_freeze_en, freeze_req, sig_reinsert_en, mismatches, comparisons} = '0;
    rx_ts = '0;
    v = 8'($urandom(32'h35d23b47));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (idx_tab[i])
    begin
      acc(1'b0, idx_tab[i], 8'h00, PORT);
      `CHK(rd, REG_RESET)
    end
    // random write and readback through the writable masks
    for (int r = 0; r < 3; r++)
      foreach (idx_tab[i])
      begin
        v = 8'($urandom) & msk_tab[i];
        acc(1'b1, idx_tab[i], v, PORT);
        if (i == 0)
        begin
          @(posedge pclk);
          #1;
          `CHK(crc_q, v[7])
        end
        if (i == 1) supp = v;
        acc(1'b0, idx_tab[i], 8'h00, PORT);
        `CHK(rd, v)
      end
    // another port's copy, an unmapped word and a misaligned address are refused
    acc(1'b1, HDLC_SUPP_IDX, ~supp, 1);
    `CHK(err, 1'b1)
    acc(1'b0, 14'h0000, 8'h00, PORT);
    `CHK({err, rd}, 9'h100)
    acc(1'b0, HDLC_SUPP_IDX, 8'h00, PORT, 2'h1);
    `CHK({err, rd}, 9'h100)
    acc(1'b0, HDLC_SUPP_IDX, 8'h00, PORT);
    `CHK(rd, supp)
    // last channel, then a select change that must wait for the next reset
    hdlc_reset(8'h1f);
    d = 8'($urandom);
    send_ts(5'h1f, d, 1'b0);
    `CHK(hdlc_q, {1'b1, d, ~supp})
    acc(1'b1, HDLC_CTRL_IDX, 8'h00, PORT);
    send_ts(5'h00, d, 1'b0);
    `CHK(hdlc_q.valid, 1'b0)
    hdlc_reset(8'h00);
    send_ts(5'h00, ~d, 1'b0);
    `CHK(hdlc_q, {1'b1, ~d, ~supp})
    // channel monitor keeps only the selected channel
    v = 8'($urandom) & 8'h1e;
    acc(1'b1, MON_SEL_IDX, v, PORT);
    send_ts(v[4:0], d, 1'b0);
    send_ts(v[4:0] + 5'd1, ~d, 1'b0);
    acc(1'b0, MON_VAL_IDX, 8'h00, PORT);
    `CHK(rd, d)
    // t1 ones insertion on channel 1, off then on
    acc(1'b1, ONES_MASK_IDX, 8'h01, PORT);
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, SIG_CTRL_IDX, k[0] ? 8'h10 : 8'h00, PORT);
      send_ts(5'h00, 8'ha0, 1'b1);
      @(posedge pclk);
      #1;
      `CHK({sig_valid, ser_out[0]}, {1'b1, k[0]})
      `CHK(sig_out, 4'ha)
    end
    // freeze needs the allow bit; a frozen channel keeps its held value and its history
    for (int k = 0; k < 2; k++)
    begin
      acc(1'b1, SIG_CTRL_IDX, k[0] ? 8'h06 : 8'h04, PORT);
      send_ts(5'h00, k[0] ? 8'h90 : 8'h50, 1'b0);
      @(posedge pclk);
      #1;
      `CHK({sig_change, sig_out}, {!k[0], 4'h5})
    end
    // integration reports a new value only on its third sample
    acc(1'b1, SIG_CTRL_IDX, 8'h01, PORT);
    for (int j = 0; j < 3; j++)
    begin
      send_ts(5'h00, 8'hc0, 1'b0);
      @(posedge pclk);
      #1;
      `CHK(sig_change, j == 2)
    end
    // e1 overhead mapping feeds the sa bit alone
    e1_mode <= 1'b1;
    hdlc_reset(8'h20);
    @(posedge pclk);
    sa_valid <= 1'b1;
    sa_bit   <= 1'b1;
    @(posedge pclk);
    sa_valid <= 1'b0;
    #1;
    `CHK(hdlc_q, {1'b1, 8'h01, 8'h01})
    // alternate cas criterion: lock needs a one in the previous ts16, an all-zero multiframe resyncs
    acc(1'b1, SIG_CTRL_IDX, 8'h10, PORT);
    for (int j = 0; j < 18; j++)
    begin
      send_ts(5'd16, (j == 1) ? 8'h0f : 8'h00, 1'b0);
      `CHK(resync, j == 17)
      @(posedge pclk);
      #1;
      `CHK(locked, j >= 2 && j < 17)
    end
    stop_test();
  end
endmodule : rfc_regs_bench
